// file: rtl/learn_and_cascade_control.sv
// learn execution, occupancy tracking, cascade chains and default bus drivers
//
// Notes on behaviour
// - default-SRAM-driver device drives SRAM lines when nobody places a result or on global miss.
// - default-status-driver device drives success and valid on non-search cycles or global miss.
// - bit zero of each 72-bit entry marks occupied (one) or empty (zero); a learn writes the comparand unchanged and sets only the separate occ bit.
// - both full-out lines rise after a write when no location remains empty.
// - table-full combines upstream full-out lines with this device's own full status.
// - sixteen pairs of 72-bit comparand registers capture search keys.
// - next-free pointer advances to the next free location after every write or learn; after a 144-bit learn it skips odd locations until a 72-bit learn.
// - only the first non-full device learns, at its next-free pointer.
// - 72-bit table writes one location; 144-bit table writes even then odd location.
// - learn makes an SRAM write whose low address is the next-free pointer.
// - SRAM write follows second learn cycle by 4, 5 or 6 clocks per table size.
// - default-SRAM-driver raises output-enable-low for the write cycle and the one before.
// - a 72-bit learn writes the even comparand of the indexed pair.
// - two local-hit outputs, seven local-hit inputs, one SRAM bus driver per cycle.
// - block-hit outputs carry the block result, used only from the last device.
`timescale 1ns/100ps
module learn_and_cascade_control
	import learn_cascade_pkg::*;
#(
	parameter int DEPTH = 65536
)
(
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [7:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [7:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	input wire logic command_valid_in,
	input wire logic [10:0] cmd_in,
	input wire logic key_valid_in,
	input wire logic [3:0] key_pair_in,
	input wire logic [ENTRY_W-1:0] key_even_in,
	input wire logic [ENTRY_W-1:0] key_odd_in,
	input wire logic pio_write_in,
	input wire logic [15:0] pio_addr_in,
	input wire logic pio_occupied_in,
	input wire logic result_placing_in,
	input wire logic global_miss_in,
	input wire logic search_cycle_in,
	input wire logic self_hit_in,
	input wire logic [6:0] local_hit_in,
	input wire logic [6:0] cascade_full_in,
	output logic [1:0] cascade_full_out,
	output logic table_full_out,
	output logic [1:0] local_hit_out,
	output logic [2:0] block_hit_out,
	output logic array_write_out,
	output logic [15:0] array_addr_out,
	output logic [ENTRY_W-1:0] array_data_out,
	output logic [23:0] sram_addr_bus_out,
	output logic sram_ce_n_out,
	output logic sram_we_n_out,
	output logic sram_bus_oe_out,
	output logic sram_oe_n_out,
	output logic search_success_flag_out,
	output logic search_status_valid_out,
	output logic status_oe_out
);
	localparam int AW = $clog2(DEPTH);
	initial
	begin
		if (DEPTH < 2 || DEPTH > 65536 || (DEPTH & (DEPTH - 1)) != 0)
			$error("DEPTH must be a power of two from 2 to 65536");
	end
	// ****************************************
	// register bus
	// ****************************************
	logic [31:0] ctrl;
	logic aw_held, w_held;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic full, scan_busy;
	logic [AW:0] occ_count;
	logic [AW-1:0] next_free_pointer;
	logic default_sram_driver_bit, default_status_driver_bit;
	logic [1:0] table_size_field;
	logic [4:0] device_id;
	assign default_sram_driver_bit = ctrl[CTRL_SRAM_DRV_BIT];
	assign default_status_driver_bit = ctrl[CTRL_STATUS_DRV_BIT];
	assign table_size_field = ctrl[CTRL_TABLE_SIZE_FIELD_LSB +: 2];
	assign device_id = ctrl[CTRL_ID_LSB +: 5];
	assign s_axi_awready_out = !aw_held && !s_axi_bvalid_out;
	assign s_axi_wready_out = !w_held && !s_axi_bvalid_out;
	assign s_axi_arready_out = !s_axi_rvalid_out;
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			s_axi_bvalid_out <= 1'b0;
			s_axi_bresp_out <= RESP_OKAY;
			ctrl <= CTRL_RESET;
		end
		else
		begin
			if (s_axi_awvalid_in && s_axi_awready_out)
			begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr_in;
			end
			if (s_axi_wvalid_in && s_axi_wready_out)
			begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata_in;
				w_strb <= s_axi_wstrb_in;
			end
			if (aw_held && w_held)
			begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid_out <= 1'b1;
				s_axi_bresp_out <= RESP_OKAY;
				if (aw_addr[7:2] == OFF_CTRL[7:2])
				begin
					for (int b = 0; b < 4; b++)
						if (w_strb[b])
							ctrl[8*b +: 8] <= w_data[8*b +: 8];
				end
				else if (aw_addr[7:2] != OFF_STATUS[7:2] && aw_addr[7:2] != OFF_COUNT[7:2])
					s_axi_bresp_out <= RESP_SLVERR;
			end
			if (s_axi_bvalid_out && s_axi_bready_in)
				s_axi_bvalid_out <= 1'b0;
		end
	end
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			s_axi_rvalid_out <= 1'b0;
			s_axi_rdata_out <= 32'h0000_0000;
			s_axi_rresp_out <= RESP_OKAY;
		end
		else if (s_axi_arvalid_in && s_axi_arready_out)
		begin
			s_axi_rvalid_out <= 1'b1;
			s_axi_rresp_out <= RESP_OKAY;
			s_axi_rdata_out <= 32'h0000_0000;
			unique case (s_axi_araddr_in[7:2])
				OFF_CTRL[7:2]: s_axi_rdata_out <= ctrl;
				OFF_STATUS[7:2]: s_axi_rdata_out <= {16'(next_free_pointer), 13'h0000, scan_busy,
					table_full_out, full};
				OFF_COUNT[7:2]: s_axi_rdata_out <= 32'(occ_count);
				default: s_axi_rresp_out <= RESP_SLVERR;
			endcase
		end
		else if (s_axi_rvalid_in_ack())
			s_axi_rvalid_out <= 1'b0;
	end
	function automatic logic s_axi_rvalid_in_ack();
		return s_axi_rvalid_out && s_axi_rready_in;
	endfunction
	// ****************************************
	// comparand registers and hit chain
	// ****************************************
	logic [ENTRY_W-1:0] cmp_even [PAIRS];
	logic [ENTRY_W-1:0] cmp_odd [PAIRS];
	always_ff @(posedge clk_in)
	begin
		if (key_valid_in)
		begin
			cmp_even[key_pair_in] <= key_even_in;
			cmp_odd[key_pair_in] <= key_odd_in;
		end
	end
	logic chain_hit;
	assign chain_hit = self_hit_in || (|local_hit_in);
	assign local_hit_out = {2{chain_hit}};
	assign block_hit_out = {3{chain_hit}};
	assign full = (occ_count == (AW+1)'(DEPTH));
	assign cascade_full_out = {2{full}};
	assign table_full_out = full && (&cascade_full_in);
	// ****************************************
	// learn command decode
	// ****************************************
	cmd_state_type cmd_state;
	logic [3:0] learn_pair;
	logic [2:0] learn_hi;
	logic issue, issue_mine, issue_wide;
	assign issue = (cmd_state == CMD_SECOND) && command_valid_in && cmd_in[1:0] == OP_LEARN;
	assign issue_wide = cmd_in[CMD_WIDE_BIT];
	assign issue_mine = issue && !full && (&cascade_full_in);
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			cmd_state <= CMD_IDLE;
			learn_pair <= 4'h0;
			learn_hi <= 3'h0;
		end
		else
		begin
			unique case (cmd_state)
				CMD_IDLE:
				begin
					if (command_valid_in && cmd_in[1:0] == OP_LEARN)
					begin
						cmd_state <= CMD_SECOND;
						learn_pair <= cmd_in[CMD_IDX_LSB +: 4];
						learn_hi <= cmd_in[CMD_HI_LSB +: 3];
					end
				end
				CMD_SECOND: cmd_state <= CMD_IDLE;
			endcase
		end
	end
	// ****************************************
	// data array write and occupancy
	// ****************************************
	logic occ [DEPTH];
	logic odd_pending;
	logic [AW-1:0] odd_addr;
	logic [3:0] odd_pair;
	logic occ_we, occ_val, occ_old;
	logic [AW-1:0] occ_addr;
	always_comb
	begin
		occ_we = 1'b0;
		occ_val = 1'b0;
		occ_addr = '0;
		if (issue_mine)
		begin
			occ_we = 1'b1;
			occ_val = 1'b1;
			occ_addr = issue_wide ? {next_free_pointer[AW-1:1], 1'b0} : next_free_pointer;
		end
		else if (odd_pending)
		begin
			occ_we = 1'b1;
			occ_val = 1'b1;
			occ_addr = odd_addr;
		end
		else if (pio_write_in)
		begin
			occ_we = 1'b1;
			occ_val = pio_occupied_in;
			occ_addr = pio_addr_in[AW-1:0];
		end
		occ_old = occ[occ_addr];
	end
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			for (int i = 0; i < DEPTH; i++)
				occ[i] <= 1'b0;
			occ_count <= '0;
		end
		else if (occ_we)
		begin
			occ[occ_addr] <= occ_val;
			if (occ_val && !occ_old)
				occ_count <= occ_count + 1'b1;
			else if (!occ_val && occ_old)
				occ_count <= occ_count - 1'b1;
		end
	end
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			odd_pending <= 1'b0;
			odd_addr <= '0;
			odd_pair <= 4'h0;
			array_write_out <= 1'b0;
			array_addr_out <= 16'h0000;
			array_data_out <= '0;
		end
		else
		begin
			array_write_out <= issue_mine || odd_pending || pio_write_in;
			array_addr_out <= 16'(occ_addr);
			array_data_out <= '0;
			odd_pending <= issue_mine && issue_wide;
			odd_addr <= {next_free_pointer[AW-1:1], 1'b1};
			odd_pair <= learn_pair;
			if (issue_mine)
				array_data_out <= cmp_even[learn_pair];
			else if (odd_pending)
				array_data_out <= cmp_odd[odd_pair];
			else
				array_data_out <= {{(ENTRY_W-1){1'b0}}, pio_occupied_in};
		end
	end
	// ****************************************
	// next-free pointer scan
	// ****************************************
	scan_state_type scan_state;
	logic scan_wide;
	assign scan_busy = (scan_state == SCAN_RUN);
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			scan_state <= SCAN_IDLE;
			scan_wide <= 1'b0;
			next_free_pointer <= '0;
		end
		else if (occ_we)
		begin
			scan_state <= SCAN_RUN;
			if (issue_mine)
				scan_wide <= issue_wide;
		end
		else
		begin
			unique case (scan_state)
				SCAN_IDLE: ;
				SCAN_RUN:
				begin
					if (full)
						scan_state <= SCAN_IDLE;
					else if (occ[next_free_pointer] || (scan_wide && next_free_pointer[0]))
						next_free_pointer <= next_free_pointer + 1'b1;
					else
						scan_state <= SCAN_IDLE;
				end
			endcase
		end
	end
	// ****************************************
	// learn pipeline to the SRAM write
	// ****************************************
	logic pipe_v [PIPE_LEN];
	logic pipe_mine [PIPE_LEN];
	logic [2:0] pipe_lat [PIPE_LEN];
	logic [23:0] pipe_addr [PIPE_LEN];
	logic [2:0] issue_lat;
	assign issue_lat = (table_size_field == TABLE_SIZE_FIELD_ONE) ? LAT_ONE :
		(table_size_field == TABLE_SIZE_FIELD_BLOCK) ? LAT_BLOCK : LAT_FOUR;
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			for (int k = 0; k < PIPE_LEN; k++)
			begin
				pipe_v[k] <= 1'b0;
				pipe_mine[k] <= 1'b0;
				pipe_lat[k] <= 3'h0;
				pipe_addr[k] <= 24'h000000;
			end
		end
		else
		begin
			pipe_v[0] <= issue;
			pipe_mine[0] <= issue_mine;
			pipe_lat[0] <= issue_lat;
			pipe_addr[0] <= {learn_hi, device_id, 16'(next_free_pointer)};
			for (int k = 1; k < PIPE_LEN; k++)
			begin
				pipe_v[k] <= pipe_v[k-1];
				pipe_mine[k] <= pipe_mine[k-1];
				pipe_lat[k] <= pipe_lat[k-1];
				pipe_addr[k] <= pipe_addr[k-1];
			end
		end
	end
	logic slot_any, slot_mine, slot_pre;
	logic [23:0] slot_addr;
	always_comb
	begin
		slot_any = 1'b0;
		slot_mine = 1'b0;
		slot_pre = 1'b0;
		slot_addr = 24'h000000;
		for (int k = 0; k < PIPE_LEN; k++)
		begin
			if (pipe_v[k] && 32'(pipe_lat[k]) == k + 2)
			begin
				slot_any = 1'b1;
				slot_mine = pipe_mine[k];
				slot_addr = pipe_addr[k];
			end
			if (pipe_v[k] && 32'(pipe_lat[k]) == k + 3)
				slot_pre = 1'b1;
		end
	end
	// ****************************************
	// shared SRAM and status bus drivers
	// ****************************************
	logic default_drive;
	assign default_drive = default_sram_driver_bit && !slot_any &&
		(!result_placing_in || global_miss_in);
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			sram_addr_bus_out <= 24'h000000;
			sram_ce_n_out <= 1'b1;
			sram_we_n_out <= 1'b1;
			sram_bus_oe_out <= 1'b0;
			sram_oe_n_out <= 1'b0;
			search_success_flag_out <= 1'b0;
			search_status_valid_out <= 1'b0;
			status_oe_out <= 1'b0;
		end
		else
		begin
			sram_addr_bus_out <= slot_mine ? slot_addr : 24'h000000;
			sram_ce_n_out <= !slot_mine;
			sram_we_n_out <= !slot_mine;
			sram_bus_oe_out <= slot_mine || default_drive;
			sram_oe_n_out <= default_sram_driver_bit && (slot_any || slot_pre);
			search_success_flag_out <= 1'b0;
			search_status_valid_out <= default_status_driver_bit && search_cycle_in && global_miss_in;
			status_oe_out <= default_status_driver_bit && (!search_cycle_in || global_miss_in);
		end
	end
endmodule

// file: rtl/learn_cascade_pkg.sv
// constants shared by the learn and cascade control block
package learn_cascade_pkg;
	// ****************************************
	// register map
	// ****************************************
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_COUNT = 8'h08;
	localparam int CTRL_SRAM_DRV_BIT = 0;
	localparam int CTRL_STATUS_DRV_BIT = 1;
	localparam int CTRL_TABLE_SIZE_FIELD_LSB = 2;
	localparam int CTRL_ID_LSB = 4;
	localparam int STATUS_FULL_BIT = 0;
	localparam int STATUS_TABLE_FULL_BIT = 1;
	localparam int STATUS_SCAN_BIT = 2;
	localparam int STATUS_PTR_LSB = 16;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ****************************************
	// command bus
	// ****************************************
	localparam logic [1:0] OP_LEARN = 2'h3;
	localparam int CMD_IDX_LSB = 2;
	localparam int CMD_HI_LSB = 6;
	localparam int CMD_WIDE_BIT = 6;
	// ****************************************
	// table size codes and write latency
	// ****************************************
	localparam logic [1:0] TABLE_SIZE_FIELD_ONE = 2'h0;
	localparam logic [1:0] TABLE_SIZE_FIELD_BLOCK = 2'h1;
	localparam logic [2:0] LAT_ONE = 3'h4;
	localparam logic [2:0] LAT_BLOCK = 3'h5;
	localparam logic [2:0] LAT_FOUR = 3'h6;
	localparam int PIPE_LEN = 6;
	localparam int ENTRY_W = 72;
	localparam int PAIRS = 16;
	typedef enum logic [1:0] {CMD_IDLE = 2'b01, CMD_SECOND = 2'b10} cmd_state_type;
	typedef enum logic [1:0] {SCAN_IDLE = 2'b01, SCAN_RUN = 2'b10} scan_state_type;
endpackage

// file: verification/learn_and_cascade_control_tb.sv
// self-checking bench for the learn and cascade control block
`timescale 1ns/100ps
module learn_and_cascade_control_tb
	import learn_cascade_pkg::*;
;
	logic clk_in = 1'h0, rst_in = 1'h1, s_axi_awvalid_in = 1'h0, s_axi_wvalid_in = 1'h0, s_axi_arvalid_in = 1'h0;
	logic s_axi_bready_in = 1'h1, s_axi_rready_in = 1'h1, key_valid_in = 1'h0, pio_write_in = 1'h0;
	logic pio_occupied_in = 1'h0, result_placing_in = 1'h0, global_miss_in = 1'h0, search_cycle_in = 1'h0;
	logic self_hit_in = 1'h0, command_valid_in, s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
	logic s_axi_arready_out, s_axi_rvalid_out, table_full_out, array_write_out, sram_ce_n_out, sram_we_n_out;
	logic sram_bus_oe_out, sram_oe_n_out, search_success_flag_out, search_status_valid_out, status_oe_out;
	logic [7:0] s_axi_awaddr_in = 8'h00, s_axi_araddr_in = 8'h00;
	logic [31:0] s_axi_wdata_in = 32'h0, s_axi_rdata_out, rd;
	logic [3:0] s_axi_wstrb_in = 4'hf, key_pair_in = 4'h0;
	logic [1:0] s_axi_bresp_out, s_axi_rresp_out, cascade_full_out, local_hit_out, rr;
	logic [71:0] key_even_in = 72'h0, key_odd_in = 72'h0, array_data_out, ke [16], ko [16];
	logic [15:0] pio_addr_in = 16'h0, array_addr_out;
	logic [6:0] local_hit_in = 7'h0, cascade_full_in = 7'h7f;
	logic [10:0] cmd_in;
	logic [2:0] block_hit_out;
	logic [23:0] sram_addr_bus_out;
	logic [4:0] id;
	int failures = 0, checks = 0;
	learn_and_cascade_control #(.DEPTH(16)) learn_and_cascade_control_i (.*);
	learn_host learn_host_i (.clk_in(clk_in), .command_valid_out(command_valid_in), .cmd_out(cmd_in));
	always #4 clk_in = ~clk_in;
	// ****************************************
	// helpers
	// ****************************************
	task automatic chk(input string n, input logic [71:0] e, input logic [71:0] s);
		checks++;
		if (s !== e)
		begin
			failures++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic test_done();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ta, tw, tb;
		s_axi_awaddr_in <= a;
		s_axi_wdata_in <= d;
		s_axi_awvalid_in <= 1'h1;
		s_axi_wvalid_in <= 1'h1;
		tb = 1'h0;
		while (!tb)
		begin
			@(negedge clk_in);
			ta = s_axi_awvalid_in & s_axi_awready_out;
			tw = s_axi_wvalid_in & s_axi_wready_out;
			tb = s_axi_bvalid_out;
			r = s_axi_bresp_out;
			@(posedge clk_in);
			if (ta)
				s_axi_awvalid_in <= 1'h0;
			if (tw)
				s_axi_wvalid_in <= 1'h0;
		end
	endtask
	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ta, tr;
		s_axi_araddr_in <= a;
		s_axi_arvalid_in <= 1'h1;
		tr = 1'h0;
		while (!tr)
		begin
			@(negedge clk_in);
			ta = s_axi_arvalid_in & s_axi_arready_out;
			tr = s_axi_rvalid_out;
			d = s_axi_rdata_out;
			r = s_axi_rresp_out;
			@(posedge clk_in);
			if (ta)
				s_axi_arvalid_in <= 1'h0;
		end
	endtask
	task automatic pio(input logic [15:0] a, input logic occ, input logic full);
		pio_write_in <= 1'h1;
		pio_addr_in <= a;
		pio_occupied_in <= occ;
		@(posedge clk_in);
		pio_write_in <= 1'h0;
		@(posedge clk_in);
		@(negedge clk_in);
		chk("full_out", {2{full}}, cascade_full_out);
		chk("table_full", full & (&cascade_full_in), table_full_out);
		@(posedge clk_in);
	endtask
	task automatic lrn(input logic wide, input logic [15:0] ptr, input int lat, input logic on, input logic drv);
		logic [3:0] p;
		logic [2:0] hi;
		p = 4'($urandom);
		hi = 3'($urandom);
		learn_host_i.learn(wide, p, hi);
		for (int k = 1; k <= 7; k++)
		begin
			@(negedge clk_in);
			chk("array_write", on & (k == 1 | wide & k == 2), array_write_out);
			if (array_write_out === 1'h1)
			begin
				chk("array_addr", ptr + 16'(k - 1), array_addr_out);
				chk("array_data", (k == 1) ? ke[p] : ko[p], array_data_out);
			end
			chk("sram_we_n", !(on & k == lat), sram_we_n_out);
			if (on & k == lat)
				chk("sram_addr", {hi, id, ptr}, sram_addr_bus_out);
			chk("oe_low", drv & (k == lat - 1 | k == lat), sram_oe_n_out);
		end
		@(posedge clk_in);
	endtask
	// ****************************************
	// tests
	// ****************************************
	initial
	begin
		void'($urandom(32'h6170c2a4));
		repeat (8) @(posedge clk_in);
		rst_in <= 1'h0;
		@(posedge clk_in);
		axr(8'h00, rd, rr);
		chk("ctrl", CTRL_RESET, rd);
		axw(8'h04, 32'hffff_ffff, rr);
		chk("ro_resp", RESP_OKAY, rr);
		axr(8'h04, rd, rr);
		chk("status", 32'h0, rd & 32'hffff_fffb);
		axr(8'h0c, rd, rr);
		chk("bad_read", {RESP_SLVERR, 32'h0}, {rr, rd});
		axw(8'h0c, 32'h1, rr);
		chk("bad_write", RESP_SLVERR, rr);
		$display("test registers done");
		id = 5'($urandom);
		for (int i = 0; i < 32; i++)
		begin
			if (i % 8 == 0)
				axw(8'h00, {23'h0, id, 2'h0, 2'(i / 8)}, rr);
			result_placing_in <= i[0];
			global_miss_in <= i[1];
			search_cycle_in <= i[2];
			self_hit_in <= 1'($urandom);
			local_hit_in <= 7'($urandom) >> ($urandom % 8);
			repeat (2) @(posedge clk_in);
			@(negedge clk_in);
			chk("sram_drive", i[3] & (!i[0] | i[1]), sram_bus_oe_out);
			chk("sram_idle", 2'h3, {sram_ce_n_out, sram_we_n_out});
			chk("status_drive", i[4] & (!i[2] | i[1]), status_oe_out);
			if (i[4])
				chk("status_valid", i[2] & i[1], search_status_valid_out);
			chk("status_success", 1'h0, search_success_flag_out);
			chk("hits", {5{self_hit_in | (|local_hit_in)}}, {block_hit_out, local_hit_out});
			@(posedge clk_in);
		end
		result_placing_in <= 1'h0;
		search_cycle_in <= 1'h0;
		$display("test drivers done");
		for (int p = 0; p < 16; p++)
		begin
			ke[p] = {8'($urandom), $urandom, $urandom};
			ko[p] = {8'($urandom), $urandom, $urandom};
			key_valid_in <= 1'h1;
			key_pair_in <= 4'(p);
			key_even_in <= ke[p];
			key_odd_in <= ko[p];
			@(posedge clk_in);
			key_valid_in <= 1'h0;
			@(posedge clk_in);
		end
		for (int k = 0; k < 5; k++)
		begin
			axw(8'h00, {23'h0, id, 2'(k % 3), 2'h1}, rr);
			lrn(k == 4, 16'(k), 4 + k % 3, 1'h1, 1'h1);
			axr(8'h04, rd, rr);
			chk("pointer", 16'(k + 1 + k / 4), rd[31:16]);
		end
		cascade_full_in <= 7'h7e;
		axw(8'h00, {23'h0, id, 2'h1, 2'h0}, rr);
		lrn(1'h0, 16'h6, 5, 1'h0, 1'h0);
		cascade_full_in <= 7'h7f;
		$display("test learn done");
		for (int a = 6; a < 16; a++)
			pio(16'(a), 1'h1, a == 15);
		cascade_full_in <= 7'h3f;
		@(negedge clk_in);
		chk("table_full", 1'h0, table_full_out);
		@(posedge clk_in);
		cascade_full_in <= 7'h7f;
		axr(8'h08, rd, rr);
		chk("count", 32'h10, rd);
		axw(8'h00, {23'h0, id, 2'h0, 2'h1}, rr);
		lrn(1'h0, 16'h0, 4, 1'h0, 1'h1);
		pio(16'h8, 1'h0, 1'h0);
		repeat (16) @(posedge clk_in);
		axr(8'h04, rd, rr);
		chk("pointer", 16'h8, rd[31:16]);
		$display("test full done");
		test_done();
	end
	initial
	begin
		repeat (5000) @(posedge clk_in);
		failures++;
		test_done();
	end
endmodule

// file: verification/learn_cascade_props.sv
// concurrent checks on the learn and cascade control ports
`timescale 1ns/100ps
module learn_cascade_props
	import learn_cascade_pkg::*;
#(
	parameter int DEPTH = 65536
)
(
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic command_valid_in,
	input wire logic [10:0] cmd_in,
	input wire logic self_hit_in,
	input wire logic [6:0] local_hit_in,
	input wire logic [6:0] cascade_full_in,
	input wire logic [1:0] cascade_full_out,
	input wire logic table_full_out,
	input wire logic [1:0] local_hit_out,
	input wire logic [2:0] block_hit_out,
	input wire logic array_write_out,
	input wire logic [15:0] array_addr_out,
	input wire logic sram_ce_n_out,
	input wire logic sram_we_n_out,
	input wire logic sram_bus_oe_out,
	input wire logic sram_oe_n_out,
	input wire logic search_success_flag_out,
	input wire logic search_status_valid_out,
	input wire logic status_oe_out
);
	// ****************************************
	// learn tracking
	// ****************************************
	logic first_seen;
	logic learn_b;
	logic learner;
	logic hit;
	assign learn_b = command_valid_in & (cmd_in[1:0] == OP_LEARN) & first_seen;
	assign learner = !cascade_full_out[0] & (&cascade_full_in);
	assign hit = self_hit_in | (|local_hit_in);
	always_ff @(posedge clk_in)
		first_seen <= !rst_in & command_valid_in & (cmd_in[1:0] == OP_LEARN) & !learn_b;
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (rst_in);
	// ****************************************
	// properties
	// ****************************************
	property p_full_pair; cascade_full_out[1] == cascade_full_out[0]; endproperty
	a_full_pair: assert property (p_full_pair) else $error("full-out lines differ");
	property p_table_full; table_full_out == (cascade_full_out[0] & (&cascade_full_in)); endproperty
	a_table_full: assert property (p_table_full) else $error("table full wrong");
	property p_local_hit; local_hit_out == {2{hit}}; endproperty
	a_local_hit: assert property (p_local_hit) else $error("local hit wrong");
	property p_block_hit; block_hit_out == {3{hit}}; endproperty
	a_block_hit: assert property (p_block_hit) else $error("block hit wrong");
	property p_oe_pulse; $rose(sram_oe_n_out) |=> sram_oe_n_out ##1 !sram_oe_n_out; endproperty
	a_oe_pulse: assert property (p_oe_pulse) else $error("oe pulse not two cycles");
	property p_learn_write; learn_b & learner |=> array_write_out ##[3:5] (!sram_we_n_out & !sram_ce_n_out); endproperty
	a_learn_write: assert property (p_learn_write) else $error("learn write missing");
	property p_wide; learn_b & learner & cmd_in[CMD_WIDE_BIT] |=> array_write_out & !array_addr_out[0]
		##1 array_write_out & array_addr_out[0]; endproperty
	a_wide: assert property (p_wide) else $error("wide learn not even then odd");
	property p_narrow; learn_b & learner & !cmd_in[CMD_WIDE_BIT] |=> array_write_out ##1 !array_write_out; endproperty
	a_narrow: assert property (p_narrow) else $error("narrow learn not single");
	property p_refuse; learn_b & !learner |=> !array_write_out [*2]; endproperty
	a_refuse: assert property (p_refuse) else $error("blocked device learned");
	property p_we_one; $fell(sram_we_n_out) |=> sram_we_n_out & sram_ce_n_out; endproperty
	a_we_one: assert property (p_we_one) else $error("sram write too long");
	property p_status; search_status_valid_out | search_success_flag_out |-> status_oe_out; endproperty
	a_status: assert property (p_status) else $error("status undriven");
endmodule
bind learn_and_cascade_control learn_cascade_props #(.DEPTH(DEPTH)) learn_cascade_props_i (.*);

// file: verification/learn_host.sv
// host model issuing learn instructions on the command bus
`timescale 1ns/100ps
module learn_host
	import learn_cascade_pkg::*;
(
	input wire logic clk_in,
	output logic command_valid_out,
	output logic [10:0] cmd_out
);
	initial
	begin
		command_valid_out = 1'h0;
		cmd_out = 11'h2a5;
	end
	// two command clocks, then valid low; never the 288-bit form
	task automatic learn(input logic wide, input logic [3:0] pair, input logic [2:0] hi);
		command_valid_out <= 1'h1;
		cmd_out <= {2'h0, hi, pair, OP_LEARN};
		@(posedge clk_in);
		cmd_out <= {4'h0, wide, pair, OP_LEARN};
		@(posedge clk_in);
		command_valid_out <= 1'h0;
		cmd_out <= ~cmd_out;
	endtask
endmodule
